// ### design/dtcru_pkg.sv
// shared constants and types of the dual timer capture/reload unit
package dtcru_pkg;
    localparam int CNT_W = 16;
    localparam int PRE_W = 9;
    localparam int SEL_OFFSET = 2;
    localparam int CTRL_W = 15;
    localparam logic [CTRL_W-1:0] CTRL_RST = 15'h0000;
    localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
    // register byte offsets
    localparam logic [7:0] OFF_CORE_CTRL = 8'h00;
    localparam logic [7:0] OFF_AUX_CTRL = 8'h04;
    localparam logic [7:0] OFF_CORE_CNT = 8'h08;
    localparam logic [7:0] OFF_AUX_CNT = 8'h0C;
    localparam logic [7:0] OFF_CAPTURE_RELOAD_REG = 8'h10;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h14;
    localparam logic [7:0] OFF_IRQ_EN = 8'h18;
    localparam logic [7:0] OFF_IRQ_CLR = 8'h1C;
    localparam logic [7:0] OFF_STATE = 8'h20;
    // control fields, common to both timers
    localparam int F_SEL = 0;
    localparam int F_EXT = 3;
    localparam int F_RUN = 4;
    localparam int F_DOWN = 5;
    localparam int F_EDIR = 6;
    localparam int F_EDGE = 7;
    // core timer only
    localparam int F_RELOAD = 9;
    localparam int F_OUTEN = 10;
    localparam int F_CUA = 11;
    localparam int F_CUB = 12;
    // aux timer only
    localparam int F_CONCAT = 9;
    localparam int F_CLRCAP = 10;
    localparam int F_CAPEDGE = 11;
    localparam int F_CAPSRC = 13;
    // interrupt status bits
    localparam int IRQ_W = 3;
    localparam int IRQ_CORE_WRAP = 0;
    localparam int IRQ_AUX_WRAP = 1;
    localparam int IRQ_CAPTURE = 2;
    // pin vector positions
    localparam int PIN_N = 7;
    localparam int PIN_CAP = 0;
    localparam int PIN_CORE_CNT = 1;
    localparam int PIN_AUX_CNT = 2;
    localparam int PIN_CORE_DIR = 3;
    localparam int PIN_AUX_DIR = 4;
    localparam int PIN_OCNT = 5;
    localparam int PIN_ODIR = 6;

    typedef enum logic [1:0] {
        EDGE_NONE = 2'h0,
        EDGE_RISE = 2'h1,
        EDGE_FALL = 2'h2,
        EDGE_BOTH = 2'h3
    } dtcru_edge_type;

    typedef enum logic [1:0] {
        CAP_PIN = 2'h0,
        CAP_OCNT = 2'h1,
        CAP_ODIR = 2'h2,
        CAP_OBOTH = 2'h3
    } dtcru_capsrc_type;

    function automatic logic edgeHit(input logic [1:0] sel, input logic rise, input logic fall);
        edgeHit = (sel[0] & rise) | (sel[1] & fall);
    endfunction
endpackage

// ### design/dtcru_tmr_if.sv
// control and status bundle between the unit and one timer
`timescale 1ns/1ns
interface dtcru_tmr_if;
    import dtcru_pkg::*;
    logic [2:0] sel;
    logic extMode;
    logic run;
    logic down;
    logic extDirEn;
    logic extDirLvl;
    logic [1:0] edgeSel;
    logic extRise;
    logic extFall;
    logic altMode;
    logic altTick;
    logic load;
    logic [CNT_W-1:0] loadVal;
    logic reloadEn;
    logic [CNT_W-1:0] reloadVal;
    logic [CNT_W-1:0] count;
    logic wrap;
    logic tick;
    modport tmr (input sel, extMode, run, down, extDirEn, extDirLvl, edgeSel, extRise, extFall,
        altMode, altTick, load, loadVal, reloadEn, reloadVal, output count, wrap, tick);
    modport ctl (output sel, extMode, run, down, extDirEn, extDirLvl, edgeSel, extRise, extFall,
        altMode, altTick, load, loadVal, reloadEn, reloadVal, input count, wrap, tick);
endinterface

// ### design/dtcru_pin_sync.sv
// two-stage pin synchroniser with edge detection
`timescale 1ns/1ns
module dtcru_pin_sync #(
    parameter int W = 7
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // pins and results
    input wire logic [W-1:0] pins,
    output logic [W-1:0] lvl,
    output logic [W-1:0] rise,
    output logic [W-1:0] fall
);
    logic [W-1:0] meta_q;
    logic [W-1:0] stab_q;
    logic [W-1:0] prev_q;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta_q <= '0;
            stab_q <= '0;
            prev_q <= '0;
        end else begin
            meta_q <= pins;
            stab_q <= meta_q;
            prev_q <= stab_q;
        end
    end

    assign lvl = stab_q;
    assign rise = stab_q & ~prev_q;
    assign fall = ~stab_q & prev_q;

    a_edge_detect: assert property (@(posedge clk) disable iff (!rstn)
        ((rise | fall) != '0) |-> ((($past(lvl) ^ lvl) & (rise | fall)) == (rise | fall)))
        else $error("edge flagged without a level change");
endmodule

// ### design/dtcru_timer.sv
// one 16-bit up/down timer with prescaler, counter and chained modes
`timescale 1ns/1ns
module dtcru_timer
    import dtcru_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // control and status
    dtcru_tmr_if.tmr tif
);
    logic [PRE_W-1:0] pre_q;
    logic [CNT_W-1:0] cnt_q;
    logic [PRE_W-1:0] mask;
    logic downEff;
    logic tick;
    logic wrap;

    // free running, so the first prescaled step after start may come early
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pre_q <= '0;
        end else begin
            pre_q <= pre_q + 1'b1;
        end
    end

    // divisor 4 for code 0, doubling to 512
    assign mask = PRE_W'((10'h001 << (4'(tif.sel) + 4'(SEL_OFFSET))) - 10'h001);
    // software direction, pin may invert it
    assign downEff = tif.down ^ (tif.extDirEn & tif.extDirLvl);

    // prescaled clock, external input or chained tick selects the count step
    always_comb begin
        if (!tif.run) begin
            tick = 1'b0;
        end else if (tif.altMode) begin
            tick = tif.altTick;
        end else if (tif.extMode) begin
            tick = edgeHit(tif.edgeSel, tif.extRise, tif.extFall);
        end else begin
            tick = (pre_q & mask) == mask;
        end
    end

    assign wrap = tick & (downEff ? (cnt_q == '0) : (cnt_q == '1));

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_q <= CNT_RST;
        end else if (tif.load) begin
            cnt_q <= tif.loadVal;
        end else if (tick) begin
            // reload lands in the wrap cycle itself
            if (wrap && tif.reloadEn) begin
                cnt_q <= tif.reloadVal;
            end else if (downEff) begin
                cnt_q <= cnt_q - 1'b1;
            end else begin
                cnt_q <= cnt_q + 1'b1;
            end
        end
    end

    assign tif.count = cnt_q;
    assign tif.wrap = wrap;
    assign tif.tick = tick;

    a_prescale_gap: assert property (@(posedge clk) disable iff (!rstn)
        (tick && !tif.extMode && !tif.altMode && tif.sel == 3'h0 && tif.run) |=> !tick [*3] ##1
        (tick || tif.sel != 3'h0 || !tif.run || tif.extMode || tif.altMode))
        else $error("prescaler divisor 4 not kept");
    a_count_up: assert property (@(posedge clk) disable iff (!rstn)
        (tick && !downEff && !wrap && !tif.load) |=> cnt_q == $past(cnt_q) + 16'h0001)
        else $error("upward step missing");
    a_ext_dir: assert property (@(posedge clk) disable iff (!rstn)
        (tick && !tif.down && tif.extDirEn && tif.extDirLvl && !wrap && !tif.load)
        |=> cnt_q == $past(cnt_q) - 16'h0001)
        else $error("direction pin ignored");
    a_ext_count: assert property (@(posedge clk) disable iff (!rstn)
        (tif.run && tif.extMode && !tif.altMode && edgeHit(tif.edgeSel, tif.extRise, tif.extFall)) |-> tick)
        else $error("external event not counted");
    a_chain_tick: assert property (@(posedge clk) disable iff (!rstn)
        (tif.run && tif.altMode) |-> (tick == tif.altTick))
        else $error("chained count mismatch");
endmodule

// ### design/dtcru_unit.sv
// dual timer capture/reload unit with APB register access
`timescale 1ns/1ns
module dtcru_unit
    import dtcru_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // apb slave
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // event pins
    input wire logic capturePin,
    input wire logic coreCountPin,
    input wire logic auxCountPin,
    input wire logic coreDirPin,
    input wire logic auxDirPin,
    input wire logic otherCountPin,
    input wire logic otherDirPin,
    // outputs
    output logic toggleLatchPin,
    output logic cuTimerATick,
    output logic cuTimerBTick,
    output logic irq
);
    logic [1:0] rstSync_q;
    logic rstn;
    logic [PIN_N-1:0] pinLvl;
    logic [PIN_N-1:0] pinRise;
    logic [PIN_N-1:0] pinFall;
    logic [CTRL_W-1:0] coreCtrl_q;
    logic [CTRL_W-1:0] auxCtrl_q;
    logic [CNT_W-1:0] capture_reload_reg_q;
    logic latch_q;
    logic pin_q;
    logic cuA_q;
    logic cuB_q;
    logic [IRQ_W-1:0] stat_q;
    logic [IRQ_W-1:0] irqEn_q;
    logic irq_q;
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic access;
    logic wrEn;
    logic capRise;
    logic capFall;
    logic capEvt;
    logic auxWr;
    logic [IRQ_W-1:0] events;
    logic [31:0] rdData;

    dtcru_tmr_if coreIf ();
    dtcru_tmr_if auxIf ();

    function automatic logic isMapped(input logic [7:0] a);
        isMapped = (a == OFF_CORE_CTRL) || (a == OFF_AUX_CTRL) || (a == OFF_CORE_CNT) ||
            (a == OFF_AUX_CNT) || (a == OFF_CAPTURE_RELOAD_REG) || (a == OFF_IRQ_STAT) ||
            (a == OFF_IRQ_EN) || (a == OFF_IRQ_CLR) || (a == OFF_STATE);
    endfunction

    // reset released through two flops
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rstSync_q <= 2'h0;
        end else begin
            rstSync_q <= {rstSync_q[0], 1'b1};
        end
    end
    assign rstn = rstSync_q[1];

    dtcru_pin_sync #(.W(PIN_N)) u_sync (
        .clk(clk),
        .rstn(rstn),
        .pins({otherDirPin, otherCountPin, auxDirPin, coreDirPin, auxCountPin, coreCountPin, capturePin}),
        .lvl(pinLvl),
        .rise(pinRise),
        .fall(pinFall)
    );

    // apb: one wait state, so write data and read data share the pready edge
    assign access = psel & penable;
    assign wrEn = access & pwrite & pready_q;
    assign auxWr = wrEn && (paddr == OFF_AUX_CNT);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h00000000;
        end else begin
            pready_q <= access & ~pready_q;
            pslverr_q <= access & ~pready_q & ~isMapped(paddr);
            if (access && !pready_q && !pwrite) begin
                prdata_q <= rdData;
            end
        end
    end

    always_comb begin
        case (paddr)
            OFF_CORE_CTRL: rdData = {17'h00000, coreCtrl_q};
            OFF_AUX_CTRL: rdData = {17'h00000, auxCtrl_q};
            OFF_CORE_CNT: rdData = {16'h0000, coreIf.count};
            OFF_AUX_CNT: rdData = {16'h0000, auxIf.count};
            OFF_CAPTURE_RELOAD_REG: rdData = {16'h0000, capture_reload_reg_q};
            OFF_IRQ_STAT: rdData = {29'h00000000, stat_q};
            OFF_IRQ_EN: rdData = {29'h00000000, irqEn_q};
            OFF_STATE: rdData = {31'h00000000, latch_q};
            default: rdData = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            coreCtrl_q <= CTRL_RST;
            auxCtrl_q <= CTRL_RST;
            irqEn_q <= '0;
        end else if (wrEn) begin
            if (paddr == OFF_CORE_CTRL) begin
                coreCtrl_q <= pwdata[CTRL_W-1:0];
            end
            if (paddr == OFF_AUX_CTRL) begin
                auxCtrl_q <= pwdata[CTRL_W-1:0];
            end
            if (paddr == OFF_IRQ_EN) begin
                irqEn_q <= pwdata[IRQ_W-1:0];
            end
        end
    end

    // core timer wiring
    assign coreIf.sel = coreCtrl_q[F_SEL +: 3];
    assign coreIf.extMode = coreCtrl_q[F_EXT];
    assign coreIf.run = coreCtrl_q[F_RUN];
    assign coreIf.down = coreCtrl_q[F_DOWN];
    assign coreIf.extDirEn = coreCtrl_q[F_EDIR];
    assign coreIf.extDirLvl = pinLvl[PIN_CORE_DIR];
    assign coreIf.edgeSel = coreCtrl_q[F_EDGE +: 2];
    assign coreIf.extRise = pinRise[PIN_CORE_CNT];
    assign coreIf.extFall = pinFall[PIN_CORE_CNT];
    assign coreIf.altMode = 1'b0;
    assign coreIf.altTick = 1'b0;
    assign coreIf.load = wrEn && (paddr == OFF_CORE_CNT);
    assign coreIf.loadVal = pwdata[CNT_W-1:0];
    // reload source is the capture register
    assign coreIf.reloadEn = coreCtrl_q[F_RELOAD];
    assign coreIf.reloadVal = capture_reload_reg_q;

    // aux timer wiring; the latch flips on every core wrap, so the wrap is its change
    assign auxIf.sel = auxCtrl_q[F_SEL +: 3];
    assign auxIf.extMode = auxCtrl_q[F_EXT];
    assign auxIf.run = auxCtrl_q[F_RUN];
    assign auxIf.down = auxCtrl_q[F_DOWN];
    assign auxIf.extDirEn = auxCtrl_q[F_EDIR];
    assign auxIf.extDirLvl = pinLvl[PIN_AUX_DIR];
    assign auxIf.edgeSel = auxCtrl_q[F_EDGE +: 2];
    assign auxIf.extRise = pinRise[PIN_AUX_CNT];
    assign auxIf.extFall = pinFall[PIN_AUX_CNT];
    assign auxIf.altMode = auxCtrl_q[F_CONCAT];
    assign auxIf.altTick = coreIf.wrap;
    // clear after capture unless software writes the count
    assign auxIf.load = auxWr | (capEvt & auxCtrl_q[F_CLRCAP]);
    assign auxIf.loadVal = auxWr ? pwdata[CNT_W-1:0] : CNT_RST;
    assign auxIf.reloadEn = 1'b0;
    assign auxIf.reloadVal = CNT_RST;

    dtcru_timer u_core (
        .clk(clk),
        .rstn(rstn),
        .tif(coreIf)
    );

    dtcru_timer u_aux (
        .clk(clk),
        .rstn(rstn),
        .tif(auxIf)
    );

    always_comb begin
        case (auxCtrl_q[F_CAPSRC +: 2])
            CAP_PIN: begin
                capRise = pinRise[PIN_CAP];
                capFall = pinFall[PIN_CAP];
            end
            CAP_OCNT: begin
                capRise = pinRise[PIN_OCNT];
                capFall = pinFall[PIN_OCNT];
            end
            CAP_ODIR: begin
                capRise = pinRise[PIN_ODIR];
                capFall = pinFall[PIN_ODIR];
            end
            default: begin
                capRise = pinRise[PIN_OCNT] | pinRise[PIN_ODIR];
                capFall = pinFall[PIN_OCNT] | pinFall[PIN_ODIR];
            end
        endcase
    end
    assign capEvt = edgeHit(auxCtrl_q[F_CAPEDGE +: 2], capRise, capFall);

    // capture beats a software write in the same cycle
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            capture_reload_reg_q <= CNT_RST;
        end else if (capEvt) begin
            capture_reload_reg_q <= auxIf.count;
        end else if (wrEn && paddr == OFF_CAPTURE_RELOAD_REG) begin
            capture_reload_reg_q <= pwdata[CNT_W-1:0];
        end
    end

    // latch flips on each core wrap
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            latch_q <= 1'b0;
        end else if (coreIf.wrap) begin
            latch_q <= ~latch_q;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pin_q <= 1'b0;
            cuA_q <= 1'b0;
            cuB_q <= 1'b0;
        end else begin
            pin_q <= latch_q & coreCtrl_q[F_OUTEN];
            cuA_q <= coreIf.wrap & coreCtrl_q[F_CUA];
            cuB_q <= coreIf.wrap & coreCtrl_q[F_CUB];
        end
    end

    // sticky events; a set in the clear cycle survives
    assign events = {capEvt, auxIf.wrap, coreIf.wrap};
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            stat_q <= '0;
            irq_q <= 1'b0;
        end else begin
            if (wrEn && paddr == OFF_IRQ_CLR) begin
                stat_q <= (stat_q & ~pwdata[IRQ_W-1:0]) | events;
            end else begin
                stat_q <= stat_q | events;
            end
            irq_q <= |(stat_q & irqEn_q);
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign toggleLatchPin = pin_q;
    assign cuTimerATick = cuA_q;
    assign cuTimerBTick = cuB_q;
    assign irq = irq_q;

    a_reload_value: assert property (@(posedge clk) disable iff (!rstn)
        (coreIf.wrap && coreIf.reloadEn && !coreIf.load) |=> coreIf.count == $past(capture_reload_reg_q))
        else $error("core reload value wrong");
    a_latch_toggle: assert property (@(posedge clk) disable iff (!rstn)
        coreIf.wrap |=> latch_q != $past(latch_q))
        else $error("toggle latch did not flip");
    a_capture_load: assert property (@(posedge clk) disable iff (!rstn)
        capEvt |=> capture_reload_reg_q == $past(auxIf.count))
        else $error("capture value wrong");
    a_clear_after: assert property (@(posedge clk) disable iff (!rstn)
        (capEvt && auxCtrl_q[F_CLRCAP] && !auxWr) |=> auxIf.count == 16'h0000)
        else $error("aux not cleared after capture");
    a_pin_follow: assert property (@(posedge clk) disable iff (!rstn)
        (coreCtrl_q[F_OUTEN] && $stable(coreCtrl_q)) |-> ##1 toggleLatchPin == $past(latch_q))
        else $error("latch pin does not follow latch");
    a_cu_tick: assert property (@(posedge clk) disable iff (!rstn)
        (coreIf.wrap && coreCtrl_q[F_CUA]) |=> cuTimerATick)
        else $error("unit timer tick missing");
    a_alt_capture: assert property (@(posedge clk) disable iff (!rstn)
        (auxCtrl_q[F_CAPSRC +: 2] == CAP_OBOTH && auxCtrl_q[F_CAPEDGE +: 2] == EDGE_BOTH &&
        (pinRise[PIN_ODIR] || pinFall[PIN_ODIR])) |-> capEvt)
        else $error("other-module capture missed");
    a_irq_level: assert property (@(posedge clk) disable iff (!rstn)
        (stat_q & irqEn_q) != '0 |=> irq)
        else $error("interrupt not raised");

    c_reload: cover property (@(posedge clk) disable iff (!rstn) coreIf.wrap && coreIf.reloadEn);
    c_capture_clear: cover property (@(posedge clk) disable iff (!rstn) capEvt && auxCtrl_q[F_CLRCAP]);
    c_chained: cover property (@(posedge clk) disable iff (!rstn) auxIf.altMode && auxIf.tick);
    c_irq: cover property (@(posedge clk) disable iff (!rstn) irq);
endmodule

// ### verification/dtcru_pin_model.sv
// model of the external event pins that face the unit
`timescale 1ns/1ns
module dtcru_pin_model
    import dtcru_pkg::*;
(
    // clock
    input wire logic clk,
    // pin levels
    output logic [PIN_N-1:0] pins
);
    initial pins = '0;
    // held 4 cycles each way, four times the shortest pulse the unit keeps
    task automatic pulse(input int idx);
        @(posedge clk);
        pins[idx] <= ~pins[idx];
        repeat (4) @(posedge clk);
        pins[idx] <= ~pins[idx];
        repeat (4) @(posedge clk);
    endtask
    task automatic level(input int idx, input logic v);
        @(posedge clk);
        pins[idx] <= v;
        repeat (4) @(posedge clk);
    endtask
endmodule

// ### verification/tb.sv
// self-checking bench of the dual timer capture/reload unit
`timescale 1ns/1ns
module tb;
    import dtcru_pkg::*;
    typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] x; logic e;} dtcru_row_type;
    logic clk, resetn, psel, penable, pwrite, pready, pslverr, latchPin, tickA, tickB, irq;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, r1, r2;
    logic e;
    logic [PIN_N-1:0] pins;
    int n_mismatch = 0, comparisons = 0, nTickA = 0, nTickB = 0;
    dtcru_row_type rows[13] = '{
        '{0, 8'h00, 0, 0, 0}, '{0, 8'h04, 0, 0, 0}, '{0, 8'h08, 0, 0, 0}, '{0, 8'h0C, 0, 0, 0},
        '{0, 8'h10, 0, 0, 0}, '{0, 8'h14, 0, 0, 0}, '{0, 8'h20, 0, 0, 0}, '{0, 8'h24, 0, 0, 1},
        '{1, 8'h14, 32'h7, 0, 0}, '{1, 8'h08, 32'hABCD, 32'hABCD, 0}, '{1, 8'h10, 32'h1234, 32'h1234, 0},
        '{1, 8'h18, 32'h5, 32'h5, 0}, '{1, 8'h1C, 32'h7, 0, 0}};

    dtcru_pin_model dtcru_pin_model_inst (.clk(clk), .pins(pins));
    dtcru_unit dtcru_unit_inst (.clk(clk), .resetn(resetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .capturePin(pins[PIN_CAP]), .coreCountPin(pins[PIN_CORE_CNT]), .auxCountPin(pins[PIN_AUX_CNT]),
        .coreDirPin(pins[PIN_CORE_DIR]), .auxDirPin(pins[PIN_AUX_DIR]), .otherCountPin(pins[PIN_OCNT]),
        .otherDirPin(pins[PIN_ODIR]), .toggleLatchPin(latchPin), .cuTimerATick(tickA),
        .cuTimerBTick(tickB), .irq(irq));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        if (tickA === 1'b1) nTickA++;
        if (tickB === 1'b1) nTickB++;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask

    // one full transfer; read data taken at the pready edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] rd, output logic err);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // no cycle count assumed; only the watchdog ends a hung wait
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic print_verdict;
        $display("mismatches %0d, comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        #4000000;
        n_mismatch++;
        print_verdict();
    end

    initial begin
        resetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        chk({latchPin, tickA, tickB, irq}, 32'h0);
        foreach (rows[i]) begin
            if (rows[i].w) apb(1'b1, rows[i].a, rows[i].d, r1, e);
            apb(1'b0, rows[i].a, 0, r1, e);
            chk(r1, rows[i].x);
            chk(e, rows[i].e);
        end
        // window of 1024 cycles between samples: 4 edges per call plus 1020
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, OFF_CORE_CTRL, (i == 1) ? 32'h13 : (i == 2) ? 32'h17 : (i == 3) ? 32'h30 : 32'h10, r1, e);
            apb(1'b0, OFF_CORE_CNT, 0, r1, e);
            repeat (1020) @(posedge clk);
            apb(1'b0, OFF_CORE_CNT, 0, r2, e);
            chk((i == 3) ? r1 - r2 : r2 - r1, 32'd1024 >> ((i == 1) ? 5 : (i == 2) ? 9 : 2));
        end
        // wrap from FFF0 at divisor 4: first wrap in 64 cycles, next 64 later
        apb(1'b1, OFF_CORE_CTRL, 0, r1, e);
        apb(1'b1, OFF_CAPTURE_RELOAD_REG, 32'hFFF0, r1, e);
        apb(1'b1, OFF_CORE_CNT, 32'hFFF0, r1, e);
        apb(1'b1, OFF_IRQ_EN, 32'h7, r1, e);
        apb(1'b1, OFF_CORE_CTRL, 32'h1E10, r1, e);
        repeat (76) @(posedge clk);
        chk(latchPin, 1'b1);
        chk(nTickA, 1);
        chk(nTickB, 1);
        chk(irq, 1'b1);
        apb(1'b1, OFF_CORE_CTRL, 32'h200, r1, e);
        apb(1'b0, OFF_CORE_CNT, 0, r1, e);
        chk(r1[15:4], 12'hFFF);
        apb(1'b0, OFF_STATE, 0, r1, e);
        chk(r1, 32'h1);
        apb(1'b1, OFF_IRQ_CLR, 32'h7, r1, e);
        repeat (2) @(posedge clk);
        chk(irq, 1'b0);
        // aux counts pin rises, capture clears it
        apb(1'b1, OFF_AUX_CTRL, 32'hCD8, r1, e);
        repeat (3) dtcru_pin_model_inst.pulse(PIN_AUX_CNT);
        apb(1'b0, OFF_AUX_CNT, 0, r1, e);
        chk(r1, 32'h3);
        dtcru_pin_model_inst.pulse(PIN_CAP);
        apb(1'b0, OFF_CAPTURE_RELOAD_REG, 0, r1, e);
        apb(1'b0, OFF_AUX_CNT, 0, r2, e);
        chk({r1[15:0], r2[15:0]}, 32'h00030000);
        dtcru_pin_model_inst.level(PIN_AUX_DIR, 1'b1);
        repeat (2) dtcru_pin_model_inst.pulse(PIN_AUX_CNT);
        apb(1'b1, OFF_AUX_CTRL, 32'h2CD8, r1, e);
        dtcru_pin_model_inst.pulse(PIN_OCNT);
        apb(1'b0, OFF_CAPTURE_RELOAD_REG, 0, r1, e);
        apb(1'b0, OFF_AUX_CNT, 0, r2, e);
        chk({r1[15:0], r2[15:0]}, 32'hFFFE0000);
        apb(1'b0, OFF_IRQ_STAT, 0, r1, e);
        chk(r1, 32'h6);
        chk(irq, 1'b1);
        // chained aux counts core wraps; counter-mode core reloads FFFE on each wrap
        apb(1'b1, OFF_CORE_CNT, 32'hFFFF, r1, e);
        apb(1'b1, OFF_AUX_CTRL, 32'h210, r1, e);
        apb(1'b1, OFF_CORE_CTRL, 32'h298, r1, e);
        repeat (3) dtcru_pin_model_inst.pulse(PIN_CORE_CNT);
        apb(1'b0, OFF_AUX_CNT, 0, r1, e);
        apb(1'b0, OFF_CORE_CNT, 0, r2, e);
        chk({r1[15:0], r2[15:0]}, 32'h0002FFFE);
        // mid-run reset clears latch, status and interrupt
        @(posedge clk);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        chk({latchPin, tickA, tickB, irq}, 32'h0);
        apb(1'b0, OFF_STATE, 0, r1, e);
        apb(1'b0, OFF_IRQ_STAT, 0, r2, e);
        chk({r1[15:0], r2[15:0]}, 32'h0);
        print_verdict();
    end
endmodule
